// ### usb_ep_controller.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module usb_ep_controller
  import usb_ep_pkg::*;
(
  // Endpoint register port
  ep_ctrl_if.ctl        bus,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq
);

  ctl_state_t         state_reg;
  logic               cmd_pend_reg;
  logic               cmd_write_reg;
  logic [7:0]         cmd_addr_reg;
  logic [7:0]         cmd_data_reg;
  logic [7:0]         rd_data_reg;
  logic               init_done_reg;
  logic               reinit_reg;
  logic               dev_irq_d_reg;
  logic [IRQ_W-1:0]   irq_stat_reg;
  logic [IRQ_W-1:0]   irq_en_reg;
  logic               apb_done;
  logic               apb_wr;
  logic               busy;
  logic               mapped;
  logic [IRQ_W-1:0]   ev;
  logic [31:0]        rd_mux;

  // Zero-wait would need a combinational pready; one wait keeps it registered
  assign apb_done = psel && penable && pready;
  assign apb_wr   = apb_done && pwrite;
  // Pending re-init counts as busy so a poll cannot slip in before it
  assign busy     = cmd_pend_reg || reinit_reg || bus.bus_rst_seen || (state_reg != ST_IDLE);
  assign mapped   = (paddr == APB_CMD) || (paddr == APB_STATUS) || (paddr == APB_IRQ_STAT)
                    || (paddr == APB_IRQ_CLR) || (paddr == APB_IRQ_EN);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      APB_CMD: begin
        rd_mux[CMD_ADDR_LSB +: 8] = cmd_addr_reg;
        rd_mux[CMD_DATA_LSB +: 8] = cmd_data_reg;
        rd_mux[CMD_WRITE_BIT]     = cmd_write_reg;
      end
      APB_STATUS: begin
        rd_mux[STAT_BUSY_BIT]      = busy;
        rd_mux[STAT_INIT_BIT]      = init_done_reg;
        rd_mux[STAT_DATA_LSB +: 8] = rd_data_reg;
      end
      APB_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_reg;
      APB_IRQ_EN:   rd_mux[IRQ_W-1:0] = irq_en_reg;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= rd_mux;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command capture; a command while busy is dropped
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      cmd_pend_reg  <= 1'b0;
      cmd_write_reg <= 1'b0;
      cmd_addr_reg  <= 8'h00;
      cmd_data_reg  <= 8'h00;
    end else if (apb_wr && (paddr == APB_CMD) && !busy) begin
      cmd_pend_reg  <= 1'b1;
      cmd_write_reg <= pwdata[CMD_WRITE_BIT];
      cmd_addr_reg  <= pwdata[CMD_ADDR_LSB +: 8];
      cmd_data_reg  <= pwdata[CMD_DATA_LSB +: 8];
    end else if (state_reg == ST_IDLE && !reinit_reg) begin
      cmd_pend_reg  <= 1'b0;
    end
  end

  // Bus reset seen while busy is kept for later
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      reinit_reg <= 1'b0;
    end else if (bus.bus_rst_seen) begin
      reinit_reg <= 1'b1;
    end else if (state_reg == ST_IDLE) begin
      reinit_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer; strobes are one-cycle pulses
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      state_reg     <= ST_INIT_IDX;
      bus.sfr_wr    <= 1'b0;
      bus.sfr_rd    <= 1'b0;
      bus.sfr_addr  <= 8'h00;
      bus.sfr_wdata <= 8'h00;
      rd_data_reg   <= 8'h00;
      init_done_reg <= 1'b0;
    end else begin
      bus.sfr_wr <= 1'b0;
      bus.sfr_rd <= 1'b0;
      unique case (state_reg)
        ST_INIT_IDX: begin
          bus.sfr_wr    <= 1'b1;
          bus.sfr_addr  <= ADDR_INDEX;
          bus.sfr_wdata <= INDEX_RESET;
          init_done_reg <= 1'b0;
          state_reg     <= ST_INIT_CON;
        end
        ST_INIT_CON: begin
          bus.sfr_wr    <= 1'b1;
          bus.sfr_addr  <= ADDR_CONTROL;
          bus.sfr_wdata <= EP0_INIT_CTRL;
          init_done_reg <= 1'b1;
          state_reg     <= ST_IDLE;
        end
        ST_IDLE: begin
          if (reinit_reg) begin
            state_reg <= ST_INIT_IDX;
          end else if (cmd_pend_reg && cmd_write_reg) begin
            bus.sfr_wr   <= 1'b1;
            bus.sfr_addr <= cmd_addr_reg;
            bus.sfr_wdata <= (cmd_addr_reg == ADDR_INDEX) ? (cmd_data_reg & INDEX_MASK)
                                                           : cmd_data_reg;
          end else if (cmd_pend_reg) begin
            bus.sfr_rd   <= 1'b1;
            bus.sfr_addr <= cmd_addr_reg;
            state_reg    <= ST_READ1;
          end
        end
        ST_READ1: state_reg <= ST_READ2;
        ST_READ2: begin
          rd_data_reg <= bus.sfr_rdata;
          state_reg   <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status; set beats clear
  always_comb begin
    ev              = '0;
    ev[IRQ_OP_DONE] = (state_reg == ST_READ2)
                      || (state_reg == ST_IDLE && !reinit_reg && cmd_pend_reg && cmd_write_reg);
    ev[IRQ_DEV]     = bus.usb_irq && !dev_irq_d_reg;
    ev[IRQ_BUS_RST] = bus.bus_rst_seen;
  end

  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      dev_irq_d_reg <= 1'b0;
      irq_stat_reg  <= '0;
      irq_en_reg    <= IRQ_EN_RESET;
      irq           <= 1'b0;
    end else begin
      dev_irq_d_reg <= bus.usb_irq;
      if (apb_wr && (paddr == APB_IRQ_CLR)) begin
        irq_stat_reg <= ev | (irq_stat_reg & ~pwdata[IRQ_W-1:0]);
      end else begin
        irq_stat_reg <= ev | irq_stat_reg;
      end
      if (apb_wr && (paddr == APB_IRQ_EN)) begin
        irq_en_reg <= pwdata[IRQ_W-1:0];
      end
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

endmodule

// ### usb_ep_pkg.sv
package usb_ep_pkg;

  // Endpoint window
  localparam int          NUM_EP         = 4;
  localparam int          EP_IDX_W       = 2;
  localparam logic [7:0]  ADDR_INDEX     = 8'hC7;
  localparam logic [7:0]  ADDR_STATUS    = 8'hCE;
  localparam logic [7:0]  ADDR_CONTROL   = 8'hD4;
  localparam logic [7:0]  INDEX_MASK     = 8'h03;
  localparam logic [7:0]  INDEX_RESET    = 8'h00;
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;

  // Control byte fields
  localparam int          BIT_ACTIVE     = 7;
  localparam int          BIT_NAK_IE     = 6;
  localparam int          BIT_NAK_OUT    = 5;
  localparam int          BIT_NAK_IN     = 4;
  localparam int          BIT_TOGGLE     = 3;
  localparam int          BIT_DIR        = 2;
  localparam int          TYPE_LSB       = 0;
  localparam logic [1:0]  TYPE_CONTROL   = 2'h0;
  localparam logic [1:0]  TYPE_ISO       = 2'h1;
  localparam logic [1:0]  TYPE_BULK      = 2'h2;

  // Endpoint 0 setup written after every reset
  localparam logic [7:0]  EP0_INIT_CTRL  = 8'h80;

  // Controller APB map
  localparam logic [7:0]  APB_CMD        = 8'h00;
  localparam logic [7:0]  APB_STATUS     = 8'h04;
  localparam logic [7:0]  APB_IRQ_STAT   = 8'h08;
  localparam logic [7:0]  APB_IRQ_CLR    = 8'h0C;
  localparam logic [7:0]  APB_IRQ_EN     = 8'h10;
  localparam int          CMD_ADDR_LSB   = 0;
  localparam int          CMD_DATA_LSB   = 8;
  localparam int          CMD_WRITE_BIT  = 16;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_INIT_BIT  = 1;
  localparam int          STAT_DATA_LSB  = 8;
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_OP_DONE    = 0;
  localparam int          IRQ_DEV        = 1;
  localparam int          IRQ_BUS_RST    = 2;
  localparam logic [2:0]  IRQ_EN_RESET   = 3'h0;

  typedef enum logic [2:0] {
    ST_INIT_IDX = 3'b000,
    ST_INIT_CON = 3'b001,
    ST_IDLE     = 3'b010,
    ST_READ1    = 3'b011,
    ST_READ2    = 3'b100
  } ctl_state_t;

endpackage

// ### ep_ctrl_if.sv
`timescale 1ns/1ns
interface ep_ctrl_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       usb_irq;
  logic       bus_rst_seen;

  modport dev (
    input  pclk, presetn, sfr_addr, sfr_wr, sfr_rd, sfr_wdata,
    output sfr_rdata, usb_irq, bus_rst_seen
  );

  modport ctl (
    input  pclk, presetn, sfr_rdata, usb_irq, bus_rst_seen,
    output sfr_addr, sfr_wr, sfr_rd, sfr_wdata
  );
endinterface

// ### usb_ep_device.sv
`timescale 1ns/1ns
module usb_ep_device
  import usb_ep_pkg::*;
(
  // Register side
  ep_ctrl_if.dev                       bus,
  // NAK handshake events from the USB engine
  input  wire logic                    nak_out_evt,
  input  wire logic                    nak_in_evt,
  input  wire logic [EP_IDX_W-1:0]     nak_ep,
  // Data packet received
  input  wire logic                    rx_data_valid,
  input  wire logic [EP_IDX_W-1:0]     rx_data_ep,
  input  wire logic                    rx_data1,
  // USB bus reset pulse
  input  wire logic                    usb_bus_reset,
  // Endpoint configuration to the USB engine
  output logic      [NUM_EP-1:0]       ep_active,
  output logic      [2*NUM_EP-1:0]     ep_transfer_type,
  output logic      [NUM_EP-1:0]       ep_in_dir
);

  logic [EP_IDX_W-1:0] index_reg;
  logic [NUM_EP-1:0]   active_reg;
  logic [NUM_EP-1:0]   nak_ie_reg;
  logic [NUM_EP-1:0]   nak_out_reg;
  logic [NUM_EP-1:0]   nak_in_reg;
  logic [NUM_EP-1:0]   toggle_reg;
  logic [NUM_EP-1:0]   dir_reg;
  logic [1:0]          type_reg [NUM_EP];
  logic                wr_index;
  logic                wr_ctrl;
  logic [7:0]          rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [EP_IDX_W-1:0] a, input int e);
    hit = (a == e[EP_IDX_W-1:0]);
  endfunction

  function automatic logic [7:0] ctrl_byte(input logic [EP_IDX_W-1:0] e);
    logic [7:0] b;
    b                        = CONTROL_RESET;
    b[BIT_ACTIVE]            = active_reg[e];
    b[BIT_NAK_IE]            = nak_ie_reg[e];
    b[BIT_NAK_OUT]           = nak_out_reg[e];
    b[BIT_NAK_IN]            = nak_in_reg[e];
    b[BIT_TOGGLE]            = toggle_reg[e];
    b[BIT_DIR]               = dir_reg[e];
    b[TYPE_LSB+1:TYPE_LSB]   = type_reg[e];
    ctrl_byte = b;
  endfunction

  assign wr_index = bus.sfr_wr && (bus.sfr_addr == ADDR_INDEX);
  assign wr_ctrl  = bus.sfr_wr && (bus.sfr_addr == ADDR_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // Endpoint index
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      index_reg <= INDEX_RESET[EP_IDX_W-1:0];
    end else if (usb_bus_reset) begin
      index_reg <= INDEX_RESET[EP_IDX_W-1:0];
    end else if (wr_index) begin
      index_reg <= bus.sfr_wdata[EP_IDX_W-1:0];
    end
  end

  // Software configuration bits of the selected endpoint
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      active_reg <= '0;
      nak_ie_reg <= '0;
      dir_reg    <= '0;
      for (int e = 0; e < NUM_EP; e++) begin
        type_reg[e] <= TYPE_CONTROL;
      end
    end else if (usb_bus_reset) begin
      active_reg <= '0;
      nak_ie_reg <= '0;
      dir_reg    <= '0;
      for (int e = 0; e < NUM_EP; e++) begin
        type_reg[e] <= TYPE_CONTROL;
      end
    end else begin
      for (int e = 0; e < NUM_EP; e++) begin
        // window write lands on indexed endpoint
        if (wr_ctrl && hit(index_reg, e)) begin
          active_reg[e] <= bus.sfr_wdata[BIT_ACTIVE];
          nak_ie_reg[e] <= bus.sfr_wdata[BIT_NAK_IE];
          dir_reg[e]    <= bus.sfr_wdata[BIT_DIR];
          type_reg[e]   <= bus.sfr_wdata[TYPE_LSB+1:TYPE_LSB];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // NAK flags; a new event beats a clear in the same cycle
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      nak_out_reg <= '0;
      nak_in_reg  <= '0;
    end else if (usb_bus_reset) begin
      nak_out_reg <= '0;
      nak_in_reg  <= '0;
    end else begin
      for (int e = 0; e < NUM_EP; e++) begin
        // OUT NAK set, zero write clears
        if (nak_out_evt && hit(nak_ep, e)) begin
          nak_out_reg[e] <= 1'b1;
        end else if (wr_ctrl && hit(index_reg, e) && !bus.sfr_wdata[BIT_NAK_OUT]) begin
          nak_out_reg[e] <= 1'b0;
        end
        // IN NAK set, zero write clears
        if (nak_in_evt && hit(nak_ep, e)) begin
          nak_in_reg[e] <= 1'b1;
        end else if (wr_ctrl && hit(index_reg, e) && !bus.sfr_wdata[BIT_NAK_IN]) begin
          nak_in_reg[e] <= 1'b0;
        end
      end
    end
  end

  // Data toggle, hardware only; writes never reach it
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      toggle_reg <= '0;
    end else if (usb_bus_reset) begin
      toggle_reg <= '0;
    end else begin
      for (int e = 0; e < NUM_EP; e++) begin
        if (rx_data_valid && hit(rx_data_ep, e)) begin
          toggle_reg[e] <= rx_data1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; other window registers live elsewhere and read zero here
  always_comb begin
    rdata_next = 8'h00;
    unique case (bus.sfr_addr)
      ADDR_INDEX:   rdata_next = {{(8-EP_IDX_W){1'b0}}, index_reg};
      ADDR_CONTROL: rdata_next = ctrl_byte(index_reg);
      default:      rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      bus.sfr_rdata <= 8'h00;
    end else if (bus.sfr_rd) begin
      bus.sfr_rdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and bus reset report, one cycle behind the flags
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      bus.usb_irq      <= 1'b0;
      bus.bus_rst_seen <= 1'b0;
    end else begin
      bus.usb_irq      <= |(nak_ie_reg & (nak_out_reg | nak_in_reg));
      bus.bus_rst_seen <= usb_bus_reset;
    end
  end

  // Configuration to the engine, registered copies; direction is forced low on control endpoints
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      ep_active        <= '0;
      ep_transfer_type <= '0;
      ep_in_dir        <= '0;
    end else begin
      ep_active <= active_reg;
      for (int e = 0; e < NUM_EP; e++) begin
        ep_transfer_type[2*e +: 2] <= type_reg[e];
        ep_in_dir[e] <= dir_reg[e] && (type_reg[e] != TYPE_CONTROL);
      end
    end
  end

endmodule

// ### usb_ep_monitor.sv
`timescale 1ns/1ns
module usb_ep_monitor
  import usb_ep_pkg::*;
(
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       usb_irq,
  input wire logic       bus_rst_seen
);
  logic [1:0] idx_reg;
  logic [7:0] ctl_data_reg;
  logic       ctl_valid_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the selected index; bus reset clears it in the device too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_reg <= 2'h0;
    end else if (bus_rst_seen) begin
      idx_reg <= 2'h0;
    end else if (sfr_wr && sfr_addr == ADDR_INDEX) begin
      idx_reg <= sfr_wdata[1:0];
    end
  end

  // Last control byte, valid only while the window stays on one endpoint
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_valid_reg <= 1'b0;
      ctl_data_reg  <= 8'h00;
    end else if (bus_rst_seen || (sfr_wr && sfr_addr == ADDR_INDEX)) begin
      ctl_valid_reg <= 1'b0;
    end else if (sfr_wr && sfr_addr == ADDR_CONTROL) begin
      ctl_valid_reg <= 1'b1;
      ctl_data_reg  <= sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_init_index: assert property (
    $rose(presetn) |-> ##[1:3] (sfr_wr && sfr_addr == ADDR_INDEX && sfr_wdata == INDEX_RESET))
    else $error("index not reselected after reset");
  a_init_control: assert property (
    bus_rst_seen |-> ##[1:6] (sfr_wr && sfr_addr == ADDR_CONTROL && sfr_wdata == EP0_INIT_CTRL))
    else $error("endpoint 0 not set up after bus reset");
  a_index_upper_zero: assert property (
    sfr_wr && sfr_addr == ADDR_INDEX |-> (sfr_wdata & ~INDEX_MASK) == 8'h00)
    else $error("ones written to unused index bits");
  a_index_readback: assert property (
    sfr_rd && sfr_addr == ADDR_INDEX |=> sfr_rdata == {6'h00, idx_reg})
    else $error("index read back wrong");
  a_control_keeps: assert property (
    sfr_rd && sfr_addr == ADDR_CONTROL && ctl_valid_reg
    |=> ((sfr_rdata ^ ctl_data_reg) & 8'hC7) == 8'h00)
    else $error("control byte not kept");
  a_unmapped_zero: assert property (
    sfr_rd && sfr_addr != ADDR_INDEX && sfr_addr != ADDR_CONTROL |=> sfr_rdata == 8'h00)
    else $error("unmapped window read not zero");
  a_rdata_holds: assert property (
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_single_strobe: assert property (
    !(sfr_wr && sfr_rd))
    else $error("read and write strobes together");
  a_bus_reset_irq: assert property (
    bus_rst_seen |=> !usb_irq)
    else $error("interrupt survived bus reset");
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top
  import usb_ep_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, ep_transfer_type, q;
  logic [31:0] pwdata, prdata, rv;
  logic        nak_out_evt, nak_in_evt, rx_data_valid, rx_data1, usb_bus_reset, err;
  logic [1:0]  nak_ep, rx_data_ep;
  logic [3:0]  ep_active, ep_in_dir;
  logic [7:0]  cfg [4] = '{8'h84, 8'h85, 8'h86, 8'h02};
  int          num_errors, samples_checked;

  ep_ctrl_if ep_ctrl_if_i (.pclk(pclk), .presetn(presetn));
  usb_ep_device usb_ep_device_i (.bus(ep_ctrl_if_i), .nak_out_evt(nak_out_evt),
    .nak_in_evt(nak_in_evt), .nak_ep(nak_ep), .rx_data_valid(rx_data_valid),
    .rx_data_ep(rx_data_ep), .rx_data1(rx_data1), .usb_bus_reset(usb_bus_reset),
    .ep_active(ep_active), .ep_transfer_type(ep_transfer_type), .ep_in_dir(ep_in_dir));
  usb_ep_controller usb_ep_controller_i (.bus(ep_ctrl_if_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  usb_ep_monitor usb_ep_monitor_i (.pclk(pclk), .presetn(presetn),
    .sfr_addr(ep_ctrl_if_i.sfr_addr), .sfr_wr(ep_ctrl_if_i.sfr_wr),
    .sfr_rd(ep_ctrl_if_i.sfr_rd), .sfr_wdata(ep_ctrl_if_i.sfr_wdata),
    .sfr_rdata(ep_ctrl_if_i.sfr_rdata), .usb_irq(ep_ctrl_if_i.usb_irq),
    .bus_rst_seen(ep_ctrl_if_i.bus_rst_seen));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One transfer; held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("MISMATCH t=%0t no pready", $time);
    end
    rv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Commands are dropped while busy, so always wait for idle
  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      n++;
    end while (rv[1:0] !== 2'b10 && n < 50);
    if (rv[1:0] !== 2'b10) begin
      num_errors++;
      $display("MISMATCH t=%0t never idle", $time);
    end
    q = rv[STAT_DATA_LSB +: 8];
  endtask

  task automatic op(input logic wr, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, APB_CMD, {15'h0000, wr, d, a});
    idle();
  endtask

  // Kinds: 0 nak out, 1 nak in, 2 data0, 3 data1, 4 bus reset
  task automatic ev(input int k, input logic [1:0] e);
    @(posedge pclk);
    nak_ep        <= e;
    rx_data_ep    <= e;
    rx_data1      <= (k == 3);
    nak_out_evt   <= (k == 0);
    nak_in_evt    <= (k == 1);
    rx_data_valid <= (k == 2 || k == 3);
    usb_bus_reset <= (k == 4);
    @(posedge pclk);
    {nak_out_evt, nak_in_evt, rx_data_valid, usb_bus_reset} <= 4'h0;
    repeat (4) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    num_errors++;
    $display("MISMATCH t=%0t watchdog", $time);
    wrap_up();
  end

  initial begin
    {presetn, psel, penable, pwrite, nak_out_evt, nak_in_evt} = 6'h00;
    {rx_data_valid, rx_data1, usb_bus_reset} = 3'h0;
    {paddr, pwdata, nak_ep, rx_data_ep} = 44'h0;
    num_errors = 0;
    samples_checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    idle();
    // Engine outputs lag the window write by a cycle
    @(posedge pclk);
    chk({4'h0, ep_active}, 8'h01);
    op(1'b0, ADDR_CONTROL, 8'h00);
    chk(q, EP0_INIT_CTRL);
    apb(1'b0, APB_IRQ_EN, 32'h0);
    chk(rv[7:0], 8'h00);
    // Upper index bits offered as ones must come back zero
    for (int e = 0; e < 4; e++) begin
      op(1'b1, ADDR_INDEX, 8'hFC | 8'(e));
      op(1'b0, ADDR_INDEX, 8'h00);
      chk(q, 8'(e));
      op(1'b1, ADDR_CONTROL, cfg[e]);
    end
    for (int e = 0; e < 4; e++) begin
      op(1'b1, ADDR_INDEX, 8'(e));
      op(1'b0, ADDR_CONTROL, 8'h00);
      chk(q, cfg[e]);
    end
    chk({4'h0, ep_active}, 8'h07);
    chk(ep_transfer_type, 8'hA4);
    chk({4'h0, ep_in_dir}, 8'h06);
    // Flags with the NAK interrupt first off, then on
    op(1'b1, ADDR_INDEX, 8'h02);
    ev(0, 2'h2);
    op(1'b0, ADDR_CONTROL, 8'h00);
    chk(q, 8'hA6);
    apb(1'b0, APB_IRQ_STAT, 32'h0);
    chk({7'h0, rv[IRQ_DEV]}, 8'h00);
    op(1'b1, ADDR_CONTROL, 8'hF6);
    ev(1, 2'h2);
    op(1'b0, ADDR_CONTROL, 8'h00);
    chk(q, 8'hF6);
    apb(1'b0, APB_IRQ_STAT, 32'h0);
    chk({7'h0, rv[IRQ_DEV]}, 8'h01);
    chk({7'h0, irq}, 8'h00);
    apb(1'b1, APB_IRQ_EN, 32'h2);
    repeat (3) @(posedge pclk);
    chk({7'h0, irq}, 8'h01);
    op(1'b1, ADDR_CONTROL, 8'hC6);
    op(1'b0, ADDR_CONTROL, 8'h00);
    chk(q, 8'hC6);
    apb(1'b1, APB_IRQ_CLR, 32'h2);
    apb(1'b0, APB_IRQ_STAT, 32'h0);
    chk({7'h0, rv[IRQ_DEV], irq}, 8'h00);
    // Toggle survives a write that tries to clear it
    op(1'b1, ADDR_INDEX, 8'h01);
    ev(3, 2'h1);
    op(1'b1, ADDR_CONTROL, 8'h05);
    op(1'b0, ADDR_CONTROL, 8'h00);
    chk(q, 8'h0D);
    ev(2, 2'h1);
    op(1'b0, ADDR_CONTROL, 8'h00);
    chk(q, 8'h05);
    chk({4'h0, ep_active}, 8'h05);
    op(1'b0, 8'hD0, 8'h00);
    chk(q, 8'h00);
    apb(1'b0, 8'h14, 32'h0);
    chk({7'h0, err}, 8'h01);
    // Bus reset wipes config; endpoint 0 comes back as control
    ev(4, 2'h0);
    idle();
    chk({4'h0, ep_active}, 8'h01);
    chk(ep_transfer_type, 8'h00);
    chk({4'h0, ep_in_dir}, 8'h00);
    op(1'b1, ADDR_INDEX, 8'h01);
    op(1'b0, ADDR_CONTROL, 8'h00);
    chk(q, 8'h00);
    apb(1'b0, APB_IRQ_STAT, 32'h0);
    chk({5'h00, rv[IRQ_W-1:0]}, 8'h05);
    wrap_up();
  end
endmodule
